// [sgc_host.sv]
// Purpose: Host model that shifts gain words into the port
// Assumes: 400 ns serial clock made from falling clock edges
// Notes:   Serial clock idles low between frames
`timescale 1ns/10ps
module sgc_host (
  input  wire logic clk,
  output logic      serial_clk = 1'b0,
  output logic      serial_gain_in = 1'b0,
  output logic      load_enable_n = 1'b1
);
  task automatic send(input logic [7:0] w);
    @(negedge clk) load_enable_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      serial_gain_in = w[i];
      repeat (4) @(negedge clk);
      serial_clk = 1'b1;
      repeat (4) @(negedge clk);
      serial_clk = 1'b0;
    end
    repeat (4) @(negedge clk);
    load_enable_n = 1'b1;
    // Released data line must not look like a held bit
    serial_gain_in = ~serial_gain_in;
  endtask : send
endmodule : sgc_host

// [sgc_pkg.sv]
// Purpose: Shared constants for the serial gain control port
// Assumes: Single 20 MHz system clock, serial pins sampled by it
// Notes:   Gain in half-dB units: code 1 is -51, each step adds 2
package sgc_pkg;
  localparam int unsigned      CLK_HZ        = 20_000_000;
  localparam int unsigned      SYNC_STAGES   = 2;
  localparam int unsigned      SHIFT_W       = 6;
  localparam logic [5:0]       GAIN_RESET    = 6'h01;
  localparam logic [5:0]       GAIN_MIN      = 6'h01;
  localparam logic [5:0]       GAIN_MAX      = 6'h3c;
  localparam int unsigned      HDB_W         = 8;
  localparam logic signed [7:0] HDB_AT_MIN   = -8'sh33;
  localparam logic signed [7:0] HDB_PER_STEP = 8'sh02;

  typedef enum logic [2:0] {
    SGC_SLEEP    = 3'b001,
    SGC_BETWEEN  = 3'b010,
    SGC_TRANSMIT = 3'b100
  } sgc_mode_e;
endpackage : sgc_pkg

// [sgc_port.sv]
// Overview of operation
// - Shift data on serial clock rise, enable low
// - Six-bit register, MSB first, last six kept
// - Eight-bit words lose their upper two bits
// - Values above 63 keep six low bits
// - Codes 61 to 63 act as 60
// - Code 1 is -25.5 dB, 1 dB steps
// - Applied gain starts at code 1
// - Transmit enable low gives between-burst mode
// - Sleep low gives lowest-power sleep mode
// - Load enable rise applies word, blocks shifting
// - Sleep high restores normal operation
//
// Purpose: Digital control of a programmable-gain line driver
// Assumes: All pins asynchronous; serial clock well below clk/4
// Notes:   Mode pins see three flops of latency; code 0 passes as is
`timescale 1ns/10ps
module sgc_port (
  input  wire logic            clk,
  input  wire logic            nrst,
  input  wire logic            serial_clk,
  input  wire logic            serial_gain_in,
  input  wire logic            load_enable_n,
  input  wire logic            transmit_enable,
  input  wire logic            sleep_n,
  output logic [5:0]           gain_code,
  output logic signed [7:0]    gain_half_db,
  output logic                 amp_active,
  output logic                 sleep_active,
  output sgc_pkg::sgc_mode_e   mode
);
  // Synchronised pins
  logic [2:0]         link_s;
  logic [1:0]         ctrl_s;
  logic               sclk_s;
  logic               sdat_s;
  logic               len_s;
  logic               transmit_enable_s;
  logic               slp_s;

  // Edge history and detected edges
  logic               sclk_d;
  logic               len_d;
  logic               sclk_rise;
  logic               len_rise;
  logic               shift_en;

  // Shift register and the code it would apply
  logic [5:0]         shreg;
  logic [5:0]         next_shreg;
  logic [5:0]         next_gain;
  logic signed [7:0]  next_half_db;

  // Mode decode
  sgc_pkg::sgc_mode_e next_mode;
  logic               next_amp;
  logic               next_sleep;

  // Edge test shared by serial clock and load enable
  function automatic logic edge_up(
    input logic now_lvl,
    input logic old_lvl
  );
    edge_up = now_lvl & ~old_lvl;
  endfunction : edge_up

  // Upper saturation only; code 0 passes through
  function automatic logic [5:0] clamp_code(
    input logic [5:0] c
  );
    if (c > sgc_pkg::GAIN_MAX) begin
      clamp_code = sgc_pkg::GAIN_MAX;
    end else begin
      clamp_code = c;
    end
  endfunction : clamp_code

  // Half-dB units keep the half step exact in integer logic
  function automatic logic signed [7:0] code_to_hdb(
    input logic [5:0] c
  );
    logic signed [7:0] steps;
    steps = $signed({2'b00, c}) - $signed({2'b00, sgc_pkg::GAIN_MIN});
    code_to_hdb = sgc_pkg::HDB_AT_MIN + 8'(steps * sgc_pkg::HDB_PER_STEP);
  endfunction : code_to_hdb

  // Serial pins reset to their idle levels: clock low, load enable high.
  // A low reset level would fake a load enable rise and lose code 1.
  sgc_sync #(
    .W       (3),
    .RST_VAL (3'h1)
  ) u_sync_link (
    .clk  (clk),
    .nrst (nrst),
    .d    ({serial_clk, serial_gain_in, load_enable_n}),
    .q    (link_s)
  );

  // Mode pins reset low, which reads as sleep until they settle
  sgc_sync #(
    .W       (2),
    .RST_VAL (2'h0)
  ) u_sync_ctrl (
    .clk  (clk),
    .nrst (nrst),
    .d    ({transmit_enable, sleep_n}),
    .q    (ctrl_s)
  );

  assign sclk_s = link_s[2];
  assign sdat_s = link_s[1];
  assign len_s  = link_s[0];
  assign transmit_enable_s = ctrl_s[1];
  assign slp_s  = ctrl_s[0];

  // Clock history resets to the idle low level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
    end
  end

  // Load enable history resets high, so no false rise follows reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      len_d <= 1'b1;
    end else begin
      len_d <= len_s;
    end
  end

  // Shifting is shut while load enable is high
  assign sclk_rise = edge_up(sclk_s, sclk_d);
  assign len_rise  = edge_up(len_s, len_d);
  assign shift_en  = ~len_s & sclk_rise;

  // Longer words simply push their upper bits out of the top
  always_comb begin
    next_shreg = shreg;
    if (shift_en) begin
      next_shreg = {shreg[4:0], sdat_s};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shreg <= 6'h00;
    end else begin
      shreg <= next_shreg;
    end
  end

  assign next_gain    = clamp_code(shreg);
  assign next_half_db = code_to_hdb(next_gain);

  // Only a completed load changes the gain; mode pins never touch it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gain_code <= sgc_pkg::GAIN_RESET;
    end else if (len_rise) begin
      gain_code <= next_gain;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gain_half_db <= sgc_pkg::HDB_AT_MIN;
    end else if (len_rise) begin
      gain_half_db <= next_half_db;
    end
  end

  // Sleep outranks transmit enable
  always_comb begin
    next_mode = sgc_pkg::SGC_SLEEP;
    unique case ({slp_s, transmit_enable_s})
      2'b00: begin
        next_mode = sgc_pkg::SGC_SLEEP;
      end
      2'b01: begin
        next_mode = sgc_pkg::SGC_SLEEP;
      end
      2'b10: begin
        next_mode = sgc_pkg::SGC_BETWEEN;
      end
      2'b11: begin
        next_mode = sgc_pkg::SGC_TRANSMIT;
      end
    endcase
  end

  // Flags decode the next mode so they switch together with it
  assign next_amp   = (next_mode == sgc_pkg::SGC_TRANSMIT);
  assign next_sleep = (next_mode == sgc_pkg::SGC_SLEEP);

  // Reset lands in sleep, matching the mode pins' reset level
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode <= sgc_pkg::SGC_SLEEP;
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      amp_active <= 1'b0;
    end else begin
      amp_active <= next_amp;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sleep_active <= 1'b1;
    end else begin
      sleep_active <= next_sleep;
    end
  end
endmodule : sgc_port

// [sgc_port_assertions.sv]
// Purpose: Pin-level checks on the serial gain control port
// Assumes: Mode pins settle within five clocks
// Notes:   Bound into the port below the module
`timescale 1ns/10ps
module sgc_port_assertions (
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic               serial_clk,
  input wire logic               serial_gain_in,
  input wire logic               load_enable_n,
  input wire logic               transmit_enable,
  input wire logic               sleep_n,
  input wire logic               amp_active,
  input wire logic               sleep_active,
  input wire logic [5:0]         gain_code,
  input wire logic signed [7:0]  gain_half_db,
  input wire sgc_pkg::sgc_mode_e mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_sat; gain_code <= 6'h3c; endproperty
  a_sat: assert property (p_sat) else $error("sat");
  property p_db;
    gain_half_db == $signed({1'b0, gain_code, 1'b0}) - 8'sd53; endproperty
  a_db: assert property (p_db) else $error("db");
  property p_keep; (!load_enable_n) [*6] |=> $stable(gain_code); endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_lock; load_enable_n [*6] |=> $stable(gain_code); endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_slp; (!sleep_n) [*5] |-> sleep_active && !amp_active; endproperty
  a_slp: assert property (p_slp) else $error("sleep");
  property p_tx; (sleep_n && transmit_enable) [*5] |-> amp_active; endproperty
  a_tx: assert property (p_tx) else $error("tx");
  property p_idle; (sleep_n && !transmit_enable) [*5] |-> mode[1]; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  // Mode is one-hot, so the flags must match its bits
  property p_hot;
    $onehot(mode) && amp_active == mode[2] && sleep_active == mode[0];
  endproperty
  a_hot: assert property (p_hot) else $error("hot");
endmodule : sgc_port_assertions
bind sgc_port sgc_port_assertions u_chk (.*);

// [sgc_port_tb.sv]
// Purpose: Bench for the serial gain control port
// Assumes: Pins change on the falling clock edge
// Notes:   Outputs are read six clocks after each word load or mode pin change; reset checks come two to six clocks after nrst moves
`timescale 1ns/10ps
module sgc_port_tb;
  logic clk = 1'b0, nrst = 1'b0, sleep_n = 1'b1;
  logic transmit_enable = 1'b0;
  logic serial_clk, serial_gain_in, load_enable_n, amp_active, sleep_active;
  logic [5:0] gain_code;
  logic signed [7:0] gain_half_db;
  sgc_pkg::sgc_mode_e mode;
  int errors = 0, n_checks = 0;
  always #25 clk = ~clk;
  sgc_host host (.*);
  sgc_port dut (.*);
  task automatic chk(input string s, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic t_gain();
    logic [7:0] w [7] = '{8'h4b, 8'h01, 8'h3d, 8'h3e, 8'hff, 8'hc0, 8'h3c};
    logic [5:0] x [7] = '{6'h0b, 6'h01, 6'h3c, 6'h3c, 6'h3c, 6'h00, 6'h3c};
    for (int i = 0; i < 7; i++) begin
      host.send(w[i]);
      repeat (6) @(negedge clk);
      chk("gain", 8'(x[i]), 8'(gain_code));
      chk("db", 8'(2 * x[i] - 53), gain_half_db);
    end
  endtask : t_gain
  task automatic pins(input logic tx, sl, sgc_pkg::sgc_mode_e m);
    @(negedge clk);
    transmit_enable = tx;
    sleep_n = sl;
    repeat (6) @(negedge clk);
    chk("mode", 8'(m), 8'(mode));
    chk("amp", 8'(m == sgc_pkg::SGC_TRANSMIT), 8'(amp_active));
    chk("sleep", 8'(m == sgc_pkg::SGC_SLEEP), 8'(sleep_active));
    chk("kept", 8'h3c, 8'(gain_code));
  endtask : pins
  task automatic t_reset();
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    chk("rst_gain", 8'h01, 8'(gain_code));
    nrst = 1'b1;
    repeat (6) @(negedge clk);
    chk("gain_after_rst", 8'h01, 8'(gain_code));
    chk("mode_after_rst", 8'(sgc_pkg::SGC_BETWEEN), 8'(mode));
  endtask : t_reset
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  initial begin
    repeat (4) @(negedge clk);
    chk("reset", 8'h01, 8'(gain_code));
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    chk("power_up", 8'h01, 8'(gain_code));
    t_gain();
    pins(1'b1, 1'b1, sgc_pkg::SGC_TRANSMIT);
    pins(1'b1, 1'b0, sgc_pkg::SGC_SLEEP);
    pins(1'b1, 1'b1, sgc_pkg::SGC_TRANSMIT);
    pins(1'b0, 1'b1, sgc_pkg::SGC_BETWEEN);
    t_reset();
    conclude();
  end
endmodule : sgc_port_tb

// [sgc_sync.sv]
// Purpose: Two-flop synchroniser for a group of pin inputs
// Assumes: Inputs asynchronous to clk
// Notes:   First stage is read only by the second stage
`timescale 1ns/10ps
module sgc_sync #(
  parameter int unsigned  W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // Reset to the pins' idle levels so no false edge follows reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : sgc_sync
